/* File: design/core_cycle_timing.sv */
// machine-cycle sequencer, strobe, operand decode and timer prescale
// assumes instruction class info arrives synchronous to clk_i
//
// Behaviour
// RULE_01 - each machine cycle lasts four clocks with one address strobe
// RULE_02 - after reset timers tick once every twelve clocks
// RULE_03 - a fast timer mode ticks once every four clocks
// RULE_04 - external data move with data pointer takes two cycles, eight clocks
// RULE_05 - three-byte direct-to-direct move takes three cycles, twelve clocks
// RULE_06 - normally one machine cycle per instruction byte
// RULE_07 - instructions take one up to five machine cycles; here stretched external moves reach nine
// RULE_08 - results match the legacy set; only timing differs
// RULE_09 - relative offset is signed byte; 11/16-bit targets; 8/16 immediates
// RULE_10 - indirect pointer is general register zero or one, not for moves
// RULE_11 - external data moves may be stretched for slow memories
// RULE_12 - reset restores twelve-clock prescale and phase zero
// RULE_13 - multi-cycle instructions hold fetch until their last cycle
`timescale 1ns/1ps

`include "cycle_timing_params.svh"

module core_cycle_timing (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         insn_valid_i,
  input  wire logic [1:0]                   insn_bytes_i,
  input  wire logic [2:0]                   insn_extra_i,
  input  wire logic                         ext_move_i,
  input  wire logic                         ext_use_dp_i,
  input  wire logic [2:0]                   stretch_i,
  input  wire logic                         ptr_bit_i,
  input  wire cycle_timing_pkg::jump_kind_t jump_kind_i,
  input  wire logic                         imm_wide_i,
  input  wire logic [15:0]                  pc_i,
  input  wire logic [7:0]                   op1_i,
  input  wire logic [7:0]                   op2_i,
  input  wire logic                         fast_timer_i,
  output logic                              ale_o,
  output logic                              insn_ready_o,
  output logic                              fetch_hold_o,
  output logic                              insn_done_o,
  output logic                              timer_tick_o,
  output logic                              timer_fast_o,
  output logic [15:0]                       branch_target_o,
  output logic [15:0]                       imm_o,
  output logic [2:0]                        ptr_reg_o,
  output logic                              ptr_dp_o
);

  ////////////////////////////////////////////////////////////////////////
  // timing only: the datapath is untouched, so results match the old set
  function automatic logic [3:0] mc_count( // RULE_08
    input logic [1:0] bytes,
    input logic [2:0] extra,
    input logic       ext,
    input logic [2:0] stretch
  );
    logic [3:0] n;
    n = {2'b00, bytes} + {1'b0, extra}; // RULE_05 RULE_06
    if (ext) begin
      n = `MC_EXT_MOVE + {1'b0, stretch}; // RULE_04 RULE_11
    end else if (n < `MC_MIN) begin
      n = `MC_MIN; // RULE_07
    end else if (n > `MC_MAX) begin
      n = `MC_MAX; // RULE_07
    end
    return n;
  endfunction

  function automatic logic [15:0] target(
    input cycle_timing_pkg::jump_kind_t kind,
    input logic [15:0]                  pc,
    input logic [7:0]                   b1,
    input logic [7:0]                   b2
  );
    logic [15:0] t;
    t = pc;
    unique case (kind)
      cycle_timing_pkg::JK_NONE:  t = pc;
      cycle_timing_pkg::JK_REL:   // RULE_09
        t = pc + {{8{b1[`REL_SIGN_BIT]}}, b1};
      cycle_timing_pkg::JK_ABS11: // RULE_09
        t = {pc[`PAGE_HI:`PAGE_LO], b1[2:0], b2};
      cycle_timing_pkg::JK_ABS16: t = {b1, b2}; // RULE_09
    endcase
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]                     phase_r;
  logic [1:0]                     phase_nxt;
  logic [3:0]                     remain_r;
  logic [3:0]                     remain_nxt;
  cycle_timing_pkg::seq_state_t   state_r;
  logic                           mc_end;
  logic                           accept;
  logic [3:0]                     new_count;

  assign mc_end    = (phase_r == `MC_LAST_PHASE);
  assign new_count = mc_count(insn_bytes_i, insn_extra_i, ext_move_i,
                              stretch_i);
  // a new instruction starts only at a cycle boundary, after the last one
  assign accept    = insn_valid_i && mc_end && (remain_r <= `MC_MIN); // RULE_13

  always_comb begin
    phase_nxt  = phase_r + 2'h1; // RULE_01
    remain_nxt = remain_r;
    if (mc_end) begin
      if (accept) begin
        remain_nxt = new_count;
      end else if (remain_r != `MC_NONE) begin
        remain_nxt = remain_r - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase counter and strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= `MC_FIRST_PHASE; // RULE_12
      ale_o   <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      ale_o   <= (phase_nxt == `MC_FIRST_PHASE); // RULE_01
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remain_r     <= `MC_NONE;
      state_r      <= cycle_timing_pkg::SEQ_IDLE;
      insn_ready_o <= 1'b0;
      fetch_hold_o <= 1'b0;
      insn_done_o  <= 1'b0;
    end else begin
      remain_r     <= remain_nxt;
      state_r      <= (remain_nxt == `MC_NONE) ? cycle_timing_pkg::SEQ_IDLE
                                               : cycle_timing_pkg::SEQ_EXEC;
      insn_ready_o <= (phase_nxt == `MC_LAST_PHASE) &&
                      (remain_nxt <= `MC_MIN);
      fetch_hold_o <= (remain_nxt > `MC_MIN); // RULE_13
      insn_done_o  <= mc_end && (remain_r == `MC_MIN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand decode, captured when the instruction is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      branch_target_o <= 16'h0000;
      imm_o           <= 16'h0000;
      ptr_reg_o       <= 3'h0;
      ptr_dp_o        <= 1'b0;
    end else if (accept) begin
      branch_target_o <= target(jump_kind_i, pc_i, op1_i, op2_i);
      imm_o           <= imm_wide_i ? {op1_i, op2_i}    // RULE_09
                                    : {8'h00, op1_i};
      ptr_reg_o       <= {2'b00, ptr_bit_i};            // RULE_10
      ptr_dp_o        <= ext_move_i && ext_use_dp_i;    // RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  timer_prescale u_prescale (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .fast_i      (fast_timer_i),
    .tick_o      (timer_tick_o),
    .fast_mode_o (timer_fast_o)
  );

  ////////////////////////////////////////////////////////////////////////
  sequence take_ext2_s;
    accept && ext_move_i && (stretch_i == 3'h0);
  endsequence

  sequence take_mov3_s;
    accept && !ext_move_i && (insn_bytes_i == 2'h3) && (insn_extra_i == 3'h0);
  endsequence

  strobe_cadence_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    ale_o |-> ##1 !ale_o [*3] ##1 ale_o)
    else $error("strobe not once per four clocks");

  fast_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    timer_tick_o && timer_fast_o && fast_timer_i ##1 fast_timer_i [*3] |->
      !timer_tick_o ##1 timer_tick_o)
    else $error("fast tick spacing is not 4 clocks");

  ext_move_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    take_ext2_s |-> ##9 insn_done_o)
    else $error("external move not done in eight clocks");

  mov_direct_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    take_mov3_s |-> ##2 !insn_done_o [*8] ##1 !insn_done_o [*3]
      ##1 insn_done_o)
    else $error("three-byte move not done in twelve clocks");

  cycle_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    accept && !ext_move_i |-> ##[5:21] insn_done_o)
    else $error("instruction length outside one to five cycles");

  fetch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    take_ext2_s |=> fetch_hold_o [*4] ##1 !fetch_hold_o)
    else $error("fetch hold wrong during two-cycle move");

  rel_target_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    accept && jump_kind_i == cycle_timing_pkg::JK_REL |=>
      branch_target_o == $past(pc_i) + {{8{$past(op1_i[7])}}, $past(op1_i)})
    else $error("relative target not sign extended");

  ptr_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    accept |=> ptr_reg_o[2:1] == 2'b00 && ptr_reg_o[0] == $past(ptr_bit_i))
    else $error("indirect pointer not register zero or one");

  reset_state_a: assert property (@(posedge clk_i) // RULE_12
    rst_i |=> phase_r == `MC_FIRST_PHASE && !timer_fast_o &&
              state_r == cycle_timing_pkg::SEQ_IDLE)
    else $error("reset did not restore phase and prescale");

endmodule // core_cycle_timing

/* File: design/cycle_timing_params.svh */
// cycle timing constants: machine-cycle phases, prescale, cycle counts
// assumes one oscillator clock drives the whole core
`ifndef CYCLE_TIMING_PARAMS_SVH
`define CYCLE_TIMING_PARAMS_SVH

// oscillator clocks per machine cycle, and the last phase index
`define MC_CLKS          4
`define MC_FIRST_PHASE   2'h0
`define MC_LAST_PHASE    2'h3

// timer prescale: last count of the legacy and the fast rate
`define TMR_LEGACY_CLKS  12
`define TMR_LEGACY_LAST  4'hb
`define TMR_FAST_LAST    4'h3
`define TMR_CNT_ZERO     4'h0

// machine cycles per instruction
`define MC_MIN           4'h1
`define MC_MAX           4'h5
`define MC_EXT_MOVE      4'h2
`define MC_NONE          4'h0

// operand field positions
`define REL_SIGN_BIT     7
`define PAGE_HI          15
`define PAGE_LO          11

`endif

/* File: design/cycle_timing_pkg.sv */
// types shared by the cycle timing block
// no constants here; numbers live in cycle_timing_params.svh
package cycle_timing_pkg;

  typedef enum logic [1:0] {
    JK_NONE  = 2'b00,
    JK_REL   = 2'b01,
    JK_ABS11 = 2'b10,
    JK_ABS16 = 2'b11
  } jump_kind_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_EXEC = 1'b1
  } seq_state_t;

endpackage

/* File: design/timer_prescale.sv */
// counter/timer prescaler: one tick per 12 clocks, or per 4 in fast mode
// assumes fast_i is a level from core control, synchronous to clk_i
`timescale 1ns/1ps

`include "cycle_timing_params.svh"

module timer_prescale (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fast_i,
  output logic      tick_o,
  output logic      fast_mode_o
);

  logic [3:0] cnt_r;
  logic [3:0] last_cnt;

  ////////////////////////////////////////////////////////////////////////
  // rate select; reset returns to the legacy rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_mode_o <= 1'b0; // RULE_12
    end else begin
      fast_mode_o <= fast_i;
    end
  end

  assign last_cnt = fast_mode_o ? `TMR_FAST_LAST    // RULE_03
                                : `TMR_LEGACY_LAST; // RULE_02

  ////////////////////////////////////////////////////////////////////////
  // a rate change mid-period clamps the count so no tick is lost forever
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= `TMR_CNT_ZERO;
      tick_o <= 1'b0;
    end else if (cnt_r >= last_cnt) begin
      cnt_r  <= `TMR_CNT_ZERO;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 4'h1;
      tick_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checker helpers: clocks since the last tick, and whether the fast
  // rate ruled any compare of that interval; counted, not unrolled
  logic [3:0] since_tick_r;
  logic       mixed_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_tick_r <= `TMR_CNT_ZERO;
      mixed_r      <= 1'b1; // interval cut by reset is never full
    end else if (tick_o) begin
      since_tick_r <= `TMR_CNT_ZERO;
      mixed_r      <= fast_mode_o;
    end else begin
      since_tick_r <= since_tick_r + 4'h1;
      mixed_r      <= mixed_r || fast_mode_o;
    end
  end

  legacy_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    tick_o && !mixed_r && !fast_mode_o |->
      since_tick_r == `TMR_LEGACY_LAST)
    else $error("legacy tick spacing is not 12 clocks");

endmodule // timer_prescale

/* File: dv/tb_top.sv */
// self-checking bench for core_cycle_timing: strobe cadence, timer rate,
// instruction timing and operand decode
// assumes the design files are compiled first; one 250 MHz clock
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end

module tb_top;
  typedef struct {
    int          due;
    int          hold;
    logic [15:0] tgt;
    logic [15:0] imm;
    logic [2:0]  ptr;
    logic        dp;
    logic        use_tgt;
  } note_t;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        insn_valid_i, ext_move_i, ext_use_dp_i, ptr_bit_i;
  logic        imm_wide_i, fast_timer_i;
  logic [1:0]  insn_bytes_i;
  logic [2:0]  insn_extra_i, stretch_i, ptr_reg_o;
  logic [15:0] pc_i, branch_target_o, imm_o;
  logic [7:0]  op1_i, op2_i;
  logic        ale_o, insn_ready_o, fetch_hold_o, insn_done_o;
  logic        timer_tick_o, timer_fast_o, ptr_dp_o;
  cycle_timing_pkg::jump_kind_t jump_kind_i;
  note_t       notes[$];
  note_t       nt;
  int          cyc = 0;
  int          last_ale, last_tick, hold_cnt, i;
  int          error_cnt = 0;
  int          comparisons = 0;
  logic        rst_d = 1'b1;
  logic        skip = 1'b1;
  logic        prev_fast = 1'b0;
  logic [15:0] seed = 16'h0035;
  // ext, stretch, bytes, extra
  logic [8:0]  tbl [9] = '{9'b1_000_01_000, 9'b1_111_01_000, 9'b0_000_11_000,
                           9'b0_000_01_000, 9'b0_000_10_000, 9'b0_000_11_010,
                           9'b0_000_11_111, 9'b0_000_00_000, 9'b1_011_01_000};

  core_cycle_timing dut (
    .clk_i(clk_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i),
    .insn_bytes_i(insn_bytes_i), .insn_extra_i(insn_extra_i),
    .ext_move_i(ext_move_i), .ext_use_dp_i(ext_use_dp_i),
    .stretch_i(stretch_i), .ptr_bit_i(ptr_bit_i), .jump_kind_i(jump_kind_i),
    .imm_wide_i(imm_wide_i), .pc_i(pc_i), .op1_i(op1_i), .op2_i(op2_i),
    .fast_timer_i(fast_timer_i), .ale_o(ale_o), .insn_ready_o(insn_ready_o),
    .fetch_hold_o(fetch_hold_o), .insn_done_o(insn_done_o),
    .timer_tick_o(timer_tick_o), .timer_fast_o(timer_fast_o),
    .branch_target_o(branch_target_o), .imm_o(imm_o),
    .ptr_reg_o(ptr_reg_o), .ptr_dp_o(ptr_dp_o)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // watcher: outputs sampled at the falling edge, where they are settled
  always @(negedge clk_i) begin
    if (rst_i) begin
      if (rst_d) begin
        `CHK("ale_in_reset", 1'b0, ale_o)
        `CHK("fast_in_reset", 1'b0, timer_fast_o)
      end
      last_ale = -1;
      last_tick = -1;
      skip = 1'b1;
      hold_cnt = 0;
    end else begin
      if (ale_o === 1'b1) begin
        if (last_ale >= 0) `CHK("ale_gap", 4, cyc - last_ale)
        last_ale = cyc;
      end
      // an offer is only taken in the last clock of the final cycle
      if (insn_ready_o === 1'b1) begin
        if (last_ale >= 0) `CHK("ready_phase", 3, cyc - last_ale)
        `CHK("ready_in_hold", 1'b0, fetch_hold_o)
      end
      // a rate change leaves one interval of mixed length
      if (timer_fast_o !== prev_fast) skip = 1'b1;
      if (timer_tick_o === 1'b1) begin
        if (!skip && last_tick >= 0)
          `CHK("tick_gap", timer_fast_o ? 4 : 12, cyc - last_tick)
        last_tick = cyc;
        skip = 1'b0;
      end
      if (fetch_hold_o === 1'b1) hold_cnt++;
      if (insn_done_o === 1'b1) begin
        if (notes.size() == 0) `CHK("done_unasked", 0, 1)
        else begin
          nt = notes.pop_front();
          `CHK("done_cycle", nt.due, cyc)
          `CHK("hold_cycles", nt.hold, hold_cnt)
          `CHK("imm", nt.imm, imm_o)
          `CHK("ptr_reg", nt.ptr, ptr_reg_o)
          `CHK("ptr_dp", nt.dp, ptr_dp_o)
          if (nt.use_tgt) `CHK("target", nt.tgt, branch_target_o)
          hold_cnt = 0;
        end
      end
    end
    rst_d = rst_i;
    prev_fast = timer_fast_o;
  end

  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // offer one instruction, note its expectations, wait for completion
  task automatic issue(input logic [8:0] e, input logic [1:0] jk);
    note_t       n;
    int          k;
    int          nmc;
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  b;
    seed = lfsr(seed);
    pc = seed;
    seed = lfsr(seed);
    a = seed[7:0];
    b = seed[15:8];
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    {ext_move_i, stretch_i, insn_bytes_i, insn_extra_i} <= e;
    jump_kind_i <= cycle_timing_pkg::jump_kind_t'(jk);
    imm_wide_i <= a[0];
    ptr_bit_i <= b[0];
    ext_use_dp_i <= b[1];
    pc_i <= pc;
    op1_i <= a;
    op2_i <= b;
    nmc = int'(e[4:3]) + int'(e[2:0]);
    nmc = e[8] ? 2 + int'(e[7:5]) : (nmc < 1 ? 1 : (nmc > 5 ? 5 : nmc));
    n.hold = 4 * (nmc - 1);
    n.imm = a[0] ? {a, b} : {8'h00, a};
    n.ptr = {2'b00, b[0]};
    n.dp = e[8] & b[1];
    n.use_tgt = (jk != 2'b00);
    n.tgt = (jk == 2'b01) ? pc + {{8{a[7]}}, a} :
            (jk == 2'b10) ? {pc[15:11], a[2:0], b} : {a, b};
    @(negedge clk_i);
    for (k = 0; k < 100 && insn_ready_o !== 1'b1; k++) @(negedge clk_i);
    if (k == 100) begin
      error_cnt++;
      test_done();
    end
    n.due = cyc + 4 * nmc + 1;
    notes.push_back(n);
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    for (k = 0; k < 100 && notes.size() > 0; k++) @(negedge clk_i);
    if (k == 100) begin
      error_cnt++;
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {insn_valid_i, ext_move_i, ext_use_dp_i, ptr_bit_i} = 4'h0;
    {imm_wide_i, fast_timer_i, insn_bytes_i} = 4'h0;
    {insn_extra_i, stretch_i} = 6'h00;
    {pc_i, op1_i, op2_i} = 32'h0000_0000;
    jump_kind_i = cycle_timing_pkg::JK_NONE;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    for (i = 0; i < 18; i++) issue(tbl[i % 9], i[1:0]);
    fast_timer_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    // second reset with the fast rate still requested
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    fast_timer_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    issue(tbl[0], 2'b11);
    issue(tbl[6], 2'b01);
    test_done();
  end
endmodule // tb_top
